// >>> common/swt_pkg.sv
// Contract
// - Two independent 41-bit down counters, decremented once per 32 kHz period.
// - Timers halt in deep sleep; in sleep they run unless disabled.
// - Zero reached by a running timer raises interrupt, or wake event when sleeping.
// - After zero the timer keeps decrementing below zero until stopped.
// - Loaded and started timer decrements; software may stop it any time.
// - Stopped timer holds its count and produces no interrupt from stopping.
// - Readable running and expired status per timer; reading clears expired flags.
// - While asleep, timer expiry can act as the event ending sleep.
// - Calibration reference counter increments on the 16 MHz peripheral clock.
// - Calibration runs only while awake and clocked from the 32 MHz crystal.
// - Timer zero counts programmed periods; at zero the reference counter stops and holds.
// - Twenty periods at 32000 Hz give 10000 ticks; faster gives fewer.
package swt_pkg;
    localparam int CNT_W = 41;
    localparam int HI_W = 9;
    localparam int CAL_W = 32;
    localparam int NUM_TMR = 2;
    localparam int NUM_IRQ = 3;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_T0_LO = 8'h08;
    localparam logic [7:0] OFS_T0_HI = 8'h0C;
    localparam logic [7:0] OFS_T1_LO = 8'h10;
    localparam logic [7:0] OFS_T1_HI = 8'h14;
    localparam logic [7:0] OFS_CAL = 8'h18;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
    localparam logic [7:0] OFS_TMR_STEP = 8'h08;
    // Control field positions
    localparam int CTRL_START_POS = 0;
    localparam int CTRL_STOP_POS = 2;
    localparam int CTRL_SLPDIS_POS = 4;
    localparam int CTRL_CALEN_POS = 6;
    // Status field positions
    localparam int STAT_RUN_POS = 0;
    localparam int STAT_EXP_POS = 2;
    localparam int STAT_CALRUN_POS = 4;
    // Interrupt bit positions
    localparam int IRQ_CAL_POS = 2;
    // Reset values and the unit decrement step
    localparam logic [CNT_W-1:0] CNT_RST = 41'h000_0000_0000;
    localparam logic [CAL_W-1:0] CAL_RST = 32'h0000_0000;
    localparam logic [NUM_IRQ-1:0] MASK_RST = 3'h0;
    localparam logic [NUM_TMR-1:0] SLPDIS_RST = 2'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 41'h000_0000_0001;
endpackage

// >>> dv/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [3:0] bsel = 4'hF;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack;
    logic c32 = 1'b0;
    logic c16 = 1'b0;
    logic slp = 1'b0;
    logic dslp = 1'b0;
    logic xtal = 1'b1;
    logic irq;
    logic wake;
    int fail_count = 0;
    int checks = 0;
    int cyc_n = 0;
    int n;
    logic [40:0] v;
    logic [31:0] q;

    swt_top u_dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(cyc),
        .wb_stb_i(stb),
        .wb_we_i(we),
        .wb_adr_i(adr),
        .wb_sel_i(sel),
        .wb_dat_i(dat),
        .wb_dat_o(rdat),
        .wb_ack_o(ack),
        .clk32k_i(c32),
        .clk16m_i(c16),
        .sleep_i(slp),
        .deep_sleep_i(dslp),
        .xtal_clk_i(xtal),
        .irq_o(irq),
        .wake_o(wake)
    );

    // 125 MHz clock
    always #4 clk_i = ~clk_i;

    // Hang guard
    always @(posedge clk_i)
    begin
        cyc_n++;
        if (cyc_n == 90000)
        begin
            fail_count++;
            final_report();
        end
    end

    task final_report();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task ck(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Classic single Wishbone cycle, waits for ack
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= bsel;
        @(posedge clk_i);
        while (ack !== 1'b1)
            @(posedge clk_i);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask

    task rc(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        xfer(1'b0, a, 32'h0000_0000, x);
        ck(nm, x, e);
    endtask

    task ctl(input logic [31:0] d);
        wr(swt_pkg::OFS_CTRL, d);
    endtask

    function automatic logic [7:0] ta(input int i, input int h);
        return swt_pkg::OFS_T0_LO + 8'(i * 8 + h * 4);
    endfunction

    // Load and compare a 41-bit count as two words
    task ld(input int i, input logic [40:0] c);
        wr(ta(i, 0), c[31:0]);
        wr(ta(i, 1), {23'h00_0000, c[40:32]});
    endtask

    task cc(input int i, input logic [40:0] c);
        rc("cnt_lo", ta(i, 0), c[31:0]);
        rc("cnt_hi", ta(i, 1), {23'h00_0000, c[40:32]});
    endtask

    // Slow and reference ticks, never coincident
    task tk(input int k);
        repeat (k)
        begin
            @(posedge clk_i);
            c32 <= 1'b1;
            repeat (2) @(posedge clk_i);
            c32 <= 1'b0;
            repeat (3) @(posedge clk_i);
        end
    endtask

    task rp(input int k);
        repeat (k)
        begin
            @(posedge clk_i);
            c16 <= 1'b1;
            @(posedge clk_i);
            c16 <= 1'b0;
        end
    endtask

    task cr(input int p, input int r);
        repeat (p)
        begin
            rp(r);
            tk(1);
        end
    endtask

    // Full calibration over twenty slow periods
    task cal(input int r);
        wr(swt_pkg::OFS_IRQ_STAT, 32'h0000_0007);
        ctl(32'h0000_0040);
        ld(0, 41'h000_0000_0014);
        ctl(32'h0000_0041);
        rc("cal_running", swt_pkg::OFS_STAT, 32'h0000_0011);
        cr(20, r);
        rc("cal_count", swt_pkg::OFS_CAL, 32'(20 * r));
        rp(40);
        rc("cal_hold", swt_pkg::OFS_CAL, 32'(20 * r));
        rc("cal_irq", swt_pkg::OFS_IRQ_STAT, 32'h0000_0005);
        rc("cal_stat", swt_pkg::OFS_STAT, 32'h0000_0005);
        ctl(32'h0000_0004);
        $display("test calibration %0d done", r);
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(32'h71CBB819));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 9; a++)
            rc("reset_val", 8'(a * 4), 32'h0000_0000);
        wr(8'h24, $urandom);
        rc("unmapped", 8'h24, 32'h0000_0000);
        wr(swt_pkg::OFS_IRQ_MASK, 32'h0000_0005);
        rc("mask_rw", swt_pkg::OFS_IRQ_MASK, 32'h0000_0005);
        bsel = 4'hE;
        wr(swt_pkg::OFS_IRQ_MASK, 32'h0000_0002);
        bsel = 4'hF;
        rc("sel_ignored", swt_pkg::OFS_IRQ_MASK, 32'h0000_0005);
        wr(swt_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        $display("test reset done");
        for (int i = 0; i < 2; i++)
        begin
            n = 3 + $urandom % 6;
            wr(swt_pkg::OFS_IRQ_MASK, 32'(1 << i));
            ld(i, 41'(n));
            ctl(32'(1 << i));
            rc("running", swt_pkg::OFS_STAT, 32'(1 << i));
            tk(n - 1);
            cc(i, 41'h000_0000_0001);
            ck("irq_early", 32'(irq), 32'h0000_0000);
            tk(1);
            rc("expired", swt_pkg::OFS_STAT, 32'(5 << i));
            ck("irq_set", 32'(irq), 32'h0000_0001);
            rc("exp_clear", swt_pkg::OFS_STAT, 32'(1 << i));
            tk(2);
            cc(i, 41'h1FF_FFFF_FFFE);
            ctl(32'(4 << i));
            tk(2);
            cc(i, 41'h1FF_FFFF_FFFE);
            rc("stopped", swt_pkg::OFS_STAT, 32'h0000_0000);
            wr(swt_pkg::OFS_IRQ_STAT, 32'h0000_0007);
            rc("irq_stat_clr", swt_pkg::OFS_IRQ_STAT, 32'h0000_0000);
            ck("irq_low", 32'(irq), 32'h0000_0000);
            $display("test timer %0d done", i);
        end
        wr(swt_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        v = 41'({$urandom, $urandom});
        ld(0, v);
        cc(0, v);
        ctl(32'h0000_0001);
        tk(1);
        cc(0, v - 41'h000_0000_0001);
        ctl(32'h0000_0004);
        ld(1, 41'h000_0000_0005);
        ctl(32'h0000_0002);
        tk(2);
        ctl(32'h0000_0008);
        tk(3);
        cc(1, 41'h000_0000_0003);
        rc("stop_no_irq", swt_pkg::OFS_IRQ_STAT, 32'h0000_0000);
        ld(1, 41'h000_0000_0002);
        ctl(32'h0000_0002);
        tk(2);
        rc("masked_stat", swt_pkg::OFS_STAT, 32'h0000_000A);
        rc("masked_irq", swt_pkg::OFS_IRQ_STAT, 32'h0000_0002);
        ck("masked_line", 32'(irq), 32'h0000_0000);
        ctl(32'h0000_0008);
        wr(swt_pkg::OFS_IRQ_STAT, 32'h0000_0007);
        $display("test stop and mask done");
        wr(swt_pkg::OFS_IRQ_MASK, 32'h0000_0001);
        ld(0, 41'h000_0000_0004);
        ctl(32'h0000_0001);
        dslp <= 1'b1;
        tk(2);
        cc(0, 41'h000_0000_0004);
        dslp <= 1'b0;
        slp <= 1'b1;
        ctl(32'h0000_0010);
        rc("ctrl_rd", swt_pkg::OFS_CTRL, 32'h0000_0010);
        tk(2);
        cc(0, 41'h000_0000_0004);
        ctl(32'h0000_0000);
        tk(3);
        ck("wake_early", 32'(wake), 32'h0000_0000);
        tk(1);
        rc("sleep_exp", swt_pkg::OFS_STAT, 32'h0000_0005);
        ck("wake_set", 32'(wake), 32'h0000_0001);
        slp <= 1'b0;
        ctl(32'h0000_0004);
        wr(swt_pkg::OFS_IRQ_STAT, 32'h0000_0007);
        wr(swt_pkg::OFS_IRQ_MASK, 32'h0000_0000);
        $display("test sleep done");
        cal(500);
        cal(450);
        ctl(32'h0000_0040);
        ld(0, 41'h000_0000_0014);
        ctl(32'h0000_0041);
        cr(3, 10);
        xtal <= 1'b0;
        cr(5, 10);
        rc("cal_abort", swt_pkg::OFS_CAL, 32'h0000_001E);
        ctl(32'h0000_0004);
        xtal <= 1'b1;
        $display("test calibration abort done");
        final_report();
    end
endmodule

// >>> hw/swt_calib.sv
`timescale 1ns/10ps
// Reference counter of fast-clock ticks
module swt_calib (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ref_tick_i,
    input wire logic clear_i,
    input wire logic run_i,
    output logic [swt_pkg::CAL_W-1:0] cnt_o
);
    // Clear at the start, count while running, hold otherwise
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_o <= swt_pkg::CAL_RST;
        else if (clear_i)
            cnt_o <= swt_pkg::CAL_RST;
        else if (run_i && ref_tick_i)
            cnt_o <= cnt_o + {{(swt_pkg::CAL_W-1){1'b0}}, 1'b1};
    end
endmodule

// >>> hw/swt_timer.sv
`timescale 1ns/10ps
// One 41-bit down counter with load, start and stop
module swt_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic run_en_i,
    input wire logic load_lo_i,
    input wire logic load_hi_i,
    input wire logic [31:0] wdata_i,
    input wire logic start_i,
    input wire logic stop_i,
    output logic [swt_pkg::CNT_W-1:0] cnt_o,
    output logic running_o,
    output logic expire_o
);
    logic step;

    // Decrement only when running, ticking and not halted by sleep
    assign step = running_o && tick_i && run_en_i;

    // Run flag: stop takes priority over start
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            running_o <= 1'b0;
        else if (stop_i)
            running_o <= 1'b0;
        else if (start_i)
            running_o <= 1'b1;
    end

    // Count: loads by halves, else decrements through and below zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cnt_o <= swt_pkg::CNT_RST;
        else if (load_lo_i)
            cnt_o[31:0] <= wdata_i;
        else if (load_hi_i)
            cnt_o[swt_pkg::CNT_W-1:32] <= wdata_i[swt_pkg::HI_W-1:0];
        else if (step)
            cnt_o <= cnt_o - swt_pkg::CNT_ONE;
    end

    // Expiry pulse when the count steps from one to zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            expire_o <= 1'b0;
        else
            expire_o <= step && (cnt_o == swt_pkg::CNT_ONE) && !stop_i;
    end
endmodule

// >>> hw/swt_top.sv
`timescale 1ns/10ps
// Two wake-up timers with RC calibration, Wishbone slave
module swt_top (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic clk32k_i,
    input wire logic clk16m_i,
    input wire logic sleep_i,
    input wire logic deep_sleep_i,
    input wire logic xtal_clk_i,
    output logic irq_o,
    output logic wake_o
);
    logic slow_q;
    logic fast_q;
    logic slow_tick;
    logic fast_tick;
    logic acc;
    logic wr;
    logic rd;
    logic run_en;
    logic cal_allow;
    logic cal_start;
    logic cal_run_q;
    logic cal_en_q;
    logic [swt_pkg::NUM_TMR-1:0] slpdis_q;
    logic [swt_pkg::NUM_TMR-1:0] start;
    logic [swt_pkg::NUM_TMR-1:0] stop;
    logic [swt_pkg::NUM_TMR-1:0] running;
    logic [swt_pkg::NUM_TMR-1:0] expire;
    logic [swt_pkg::NUM_TMR-1:0] exp_q;
    logic [swt_pkg::NUM_TMR-1:0] run_gate;
    logic [swt_pkg::CNT_W-1:0] cnt [swt_pkg::NUM_TMR];
    logic [swt_pkg::CAL_W-1:0] cal_cnt;
    logic [swt_pkg::NUM_IRQ-1:0] irq_ev;
    logic [swt_pkg::NUM_IRQ-1:0] irq_st_q;
    logic [swt_pkg::NUM_IRQ-1:0] mask_q;
    logic [31:0] rd_d;

    // Register address match
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr == ofs);
    endfunction

    // Write and read take effect on the acknowledging edge
    assign acc = wb_cyc_i && wb_stb_i && wb_ack_o;
    assign wr = acc && wb_we_i && wb_sel_i[0];
    assign rd = acc && !wb_we_i;

    // Single-cycle acknowledge, dropped after one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end

    // Edge detect of the slow and fast reference clocks
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            slow_q <= 1'b0;
            fast_q <= 1'b0;
        end
        else
        begin
            slow_q <= clk32k_i;
            fast_q <= clk16m_i;
        end
    end
    assign slow_tick = clk32k_i && !slow_q;
    assign fast_tick = clk16m_i && !fast_q;

    // Sleep gating of timer counting
    assign run_en = !deep_sleep_i;

    // Control bits: sleep disable and calibration enable
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            slpdis_q <= swt_pkg::SLPDIS_RST;
            cal_en_q <= 1'b0;
        end
        else if (wr && hit(wb_adr_i, swt_pkg::OFS_CTRL))
        begin
            slpdis_q <= wb_dat_i[swt_pkg::CTRL_SLPDIS_POS +: swt_pkg::NUM_TMR];
            cal_en_q <= wb_dat_i[swt_pkg::CTRL_CALEN_POS];
        end
    end

    // Timer instances with their strobes
    genvar g;
    generate
        for (g = 0; g < swt_pkg::NUM_TMR; g++)
        begin : g_tmr
            localparam logic [7:0] LO_OFS = 8'(swt_pkg::OFS_T0_LO + g * swt_pkg::OFS_TMR_STEP);
            localparam logic [7:0] HI_OFS = 8'(swt_pkg::OFS_T0_HI + g * swt_pkg::OFS_TMR_STEP);
            assign start[g] = wr && hit(wb_adr_i, swt_pkg::OFS_CTRL) && wb_dat_i[swt_pkg::CTRL_START_POS + g];
            assign stop[g] = wr && hit(wb_adr_i, swt_pkg::OFS_CTRL) && wb_dat_i[swt_pkg::CTRL_STOP_POS + g];
            assign run_gate[g] = run_en && !(sleep_i && slpdis_q[g]);
            swt_timer u_tmr (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .tick_i(slow_tick),
                .run_en_i(run_gate[g]),
                .load_lo_i(wr && hit(wb_adr_i, LO_OFS)),
                .load_hi_i(wr && hit(wb_adr_i, HI_OFS)),
                .wdata_i(wb_dat_i),
                .start_i(start[g]),
                .stop_i(stop[g]),
                .cnt_o(cnt[g]),
                .running_o(running[g]),
                .expire_o(expire[g])
            );
        end
    endgenerate

    // Expired flags: set on expiry regardless of mask, cleared by status read
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            exp_q <= '0;
        else if (rd && hit(wb_adr_i, swt_pkg::OFS_STAT))
            exp_q <= expire;
        else
            exp_q <= exp_q | expire;
    end

    // Calibration allowed only awake on the crystal clock
    assign cal_allow = !sleep_i && !deep_sleep_i && xtal_clk_i;
    assign cal_start = start[0] && !stop[0] && cal_en_q && cal_allow;

    // Calibration run window follows timer zero until it reaches zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            cal_run_q <= 1'b0;
        else if (!cal_allow || !cal_en_q || expire[0] || stop[0])
            cal_run_q <= 1'b0;
        else if (cal_start)
            cal_run_q <= 1'b1;
    end

    swt_calib u_cal (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ref_tick_i(fast_tick),
        .clear_i(cal_start),
        .run_i(cal_run_q && !expire[0]),
        .cnt_o(cal_cnt)
    );

    // Interrupt events: two timer expiries and calibration done
    assign irq_ev = {expire[0] && cal_run_q, expire};

    // Sticky interrupt status, write one to clear, set wins
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_st_q <= '0;
        else if (wr && hit(wb_adr_i, swt_pkg::OFS_IRQ_STAT))
            irq_st_q <= (irq_st_q & ~wb_dat_i[swt_pkg::NUM_IRQ-1:0]) | irq_ev;
        else
            irq_st_q <= irq_st_q | irq_ev;
    end

    // Interrupt mask register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            mask_q <= swt_pkg::MASK_RST;
        else if (wr && hit(wb_adr_i, swt_pkg::OFS_IRQ_MASK))
            mask_q <= wb_dat_i[swt_pkg::NUM_IRQ-1:0];
    end

    // Interrupt and wake request, only for enabled sources
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_o <= 1'b0;
            wake_o <= 1'b0;
        end
        else
        begin
            irq_o <= |(irq_st_q & mask_q);
            wake_o <= sleep_i && |(irq_st_q[swt_pkg::NUM_TMR-1:0] & mask_q[swt_pkg::NUM_TMR-1:0]);
        end
    end

    // Read data mux
    always_comb
    begin
        rd_d = 32'h0000_0000;
        case (wb_adr_i)
            swt_pkg::OFS_CTRL:
            begin
                rd_d[swt_pkg::CTRL_SLPDIS_POS +: swt_pkg::NUM_TMR] = slpdis_q;
                rd_d[swt_pkg::CTRL_CALEN_POS] = cal_en_q;
            end
            swt_pkg::OFS_STAT:
            begin
                rd_d[swt_pkg::STAT_RUN_POS +: swt_pkg::NUM_TMR] = running;
                rd_d[swt_pkg::STAT_EXP_POS +: swt_pkg::NUM_TMR] = exp_q | expire;
                rd_d[swt_pkg::STAT_CALRUN_POS] = cal_run_q;
            end
            swt_pkg::OFS_T0_LO: rd_d = cnt[0][31:0];
            swt_pkg::OFS_T0_HI: rd_d[swt_pkg::HI_W-1:0] = cnt[0][swt_pkg::CNT_W-1:32];
            swt_pkg::OFS_T1_LO: rd_d = cnt[1][31:0];
            swt_pkg::OFS_T1_HI: rd_d[swt_pkg::HI_W-1:0] = cnt[1][swt_pkg::CNT_W-1:32];
            swt_pkg::OFS_CAL: rd_d = cal_cnt;
            swt_pkg::OFS_IRQ_STAT: rd_d[swt_pkg::NUM_IRQ-1:0] = irq_st_q;
            swt_pkg::OFS_IRQ_MASK: rd_d[swt_pkg::NUM_IRQ-1:0] = mask_q;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // Read data register, loaded with the acknowledge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i)
            wb_dat_o <= rd_d;
    end

    // Checks on timer, calibration and bus behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held longer than one cycle");

    property p_deep_hold;
        deep_sleep_i && !wr |=> cnt[0] == $past(cnt[0]);
    endproperty
    a_deep_hold: assert property (p_deep_hold) else $error("timer moved in deep sleep");

    property p_stop_hold;
        stop[0] |=> (!running[0] and (!wr [*2] |-> $stable(cnt[0])));
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stopped timer changed");

    property p_expire_step;
        running[0] && slow_tick && run_gate[0] && cnt[0] == swt_pkg::CNT_ONE && !wr |=> expire[0] && cnt[0] == '0;
    endproperty
    a_expire_step: assert property (p_expire_step) else $error("timer zero not flagged");

    property p_below_zero;
        running[0] && slow_tick && run_gate[0] && cnt[0] == '0 && !wr |=> cnt[0] == '1;
    endproperty
    a_below_zero: assert property (p_below_zero) else $error("timer did not pass below zero");

    property p_exp_flag;
        expire[1] |=> exp_q[1];
    endproperty
    a_exp_flag: assert property (p_exp_flag) else $error("expired flag lost");

    property p_rd_clear;
        rd && hit(wb_adr_i, swt_pkg::OFS_STAT) && !expire[0] |=> !exp_q[0];
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("status read did not clear flag");

    property p_cal_awake;
        !cal_allow |=> !cal_run_q;
    endproperty
    a_cal_awake: assert property (p_cal_awake) else $error("calibration ran while not allowed");

    property p_cal_freeze;
        cal_run_q && expire[0] |=> (!cal_run_q and (!cal_start [*2] |-> $stable(cal_cnt)));
    endproperty
    a_cal_freeze: assert property (p_cal_freeze) else $error("reference count moved after stop");

    property p_irq_gate;
        !(|(irq_st_q & mask_q)) |=> !irq_o;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("masked event raised interrupt");

    property p_wake_sleep;
        wake_o |-> $past(sleep_i);
    endproperty
    a_wake_sleep: assert property (p_wake_sleep) else $error("wake raised while awake");

    property p_ack_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_req: assert property (p_ack_req) else $error("request not acknowledged");

    property p_start_run;
        start[1] && !stop[1] |=> running[1];
    endproperty
    a_start_run: assert property (p_start_run) else $error("started timer not running");

    property p_stop_run;
        stop[1] |=> !running[1];
    endproperty
    a_stop_run: assert property (p_stop_run) else $error("stopped timer still running");

    property p_exp_single;
        expire[0] |=> !expire[0];
    endproperty
    a_exp_single: assert property (p_exp_single) else $error("expiry pulse longer than one cycle");

    property p_irq_stat;
        expire[0] |=> irq_st_q[0];
    endproperty
    a_irq_stat: assert property (p_irq_stat) else $error("expiry not recorded in status");

    property p_irq_set;
        (|(irq_st_q & mask_q)) |=> irq_o;
    endproperty
    a_irq_set: assert property (p_irq_set) else $error("enabled event gave no interrupt");

    property p_slp_hold;
        sleep_i && slpdis_q[0] && !wr |=> cnt[0] == $past(cnt[0]);
    endproperty
    a_slp_hold: assert property (p_slp_hold) else $error("sleep disabled timer moved");

    property p_cal_tick;
        cal_run_q && fast_tick && !expire[0] && !cal_start |=> cal_cnt == $past(cal_cnt) + 32'h0000_0001;
    endproperty
    a_cal_tick: assert property (p_cal_tick) else $error("reference tick not counted");

    property p_cal_irq;
        cal_run_q && expire[0] |=> irq_st_q[swt_pkg::IRQ_CAL_POS];
    endproperty
    a_cal_irq: assert property (p_cal_irq) else $error("calibration end not flagged");

    property p_wake_gate;
        !sleep_i |=> !wake_o;
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("wake request while awake");

    c_expire: cover property (running[0] ##1 expire[0]);
    c_cal_done: cover property (cal_run_q && expire[0]);
    c_wake: cover property (wake_o);
    c_sleep_hold: cover property (sleep_i && slpdis_q[0] && running[0]);
    c_below_zero: cover property (running[0] && cnt[0] == '1);
endmodule
